// >>> fdg_card.sv
// Behaviour
// [R01] Two locations: data, and status/index
// [R02] Index selects register behind data location
// [R03] Indices 00..08: control, address, inverted count
// [R04] Access to 0A starts ROM load
// [R05] Indices 0C..0F go to controller chip
// [R06] Control bits: drive, irq enable, increment inhibit
// [R07] Control bits: direction, side, retrigger, density
// [R08] Status: ready, sides, change, irq, loading
// [R09] Address preset bytewise with load strobes
// [R10] Inhibited increment keeps address fixed
// [R11] Count loaded inverted, one step per byte
// [R12] Count expiry drops valid memory strobe
// [R13] Map swap claim during each transfer
// [R14] Requests synchronised to phase-2 before raising
// [R15] Cycle performed only after acknowledge grant
// [R16] At most one cycle per two processor cycles
// [R17] Request only when enabled; pass chain otherwise
// [R18] Drive enables follow granted function
// [R19] Open-collector irq when chip irq and enabled
// [R20] Bus data latched before reaching chip
// [R21] Retrigger restarts head-load delay
// [R22] Divided clock enable for controller chip
// [R23] ROM load repeats writes until count expires
// [R24] Address and count advance per byte
`timescale 1ns/1ps
module fdg_card #(
  parameter int ROM_AW = 12
) (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  fdg_if.card                    bus,
  output logic      [1:0]        fdc_addr_o,
  output logic                   fdc_re_o,
  output logic                   fdc_we_o,
  output logic      [7:0]        fdc_wdata_o,
  input  wire logic [7:0]        fdc_rdata_i,
  input  wire logic              fdc_drq_i,
  input  wire logic              fdc_intrq_i,
  output logic                   fdc_clk_en_o,
  output logic                   drive_pick_bit_lo_o,
  output logic                   drive_pick_bit_hi_o,
  output logic                   side_select_o,
  output logic                   recording_density_select_o,
  output logic                   to_disk_o,
  output logic                   head_retrigger_o,
  output logic                   addr_low_preset_strobe_o,
  output logic                   addr_high_preset_strobe_o,
  output logic                   count_expired_flag_o,
  input  wire logic              drive_ready_i,
  input  wire logic              two_sided_i,
  input  wire logic              disk_change_i,
  output logic      [ROM_AW-1:0] rom_addr_o,
  input  wire logic [7:0]        rom_data_i
);

  typedef struct packed {
    logic [4:0]           s1;
    logic [4:0]           s2;
    logic [6:0]           div;
    logic [7:0]           idx;
    logic [7:0]           ctrl;
    logic [15:0]          addr;
    logic [15:0]          cnt;
    logic                 loading;
    logic [7:0]           rdata;
    logic [7:0]           fdc_wdata;
    logic [1:0]           fdc_a;
    logic                 fdc_we;
    logic                 retrig;
    logic                 addr_low_preset_strobe;
    logic                 addr_high_preset_strobe;
    logic [7:0]           dma_data;
    fdg_pkg::fdg_dma_st_t st;
  } fdg_card_state_t;

  fdg_card_state_t q_r;
  fdg_card_state_t q_nxt;
  logic            expired;
  logic            data_wr;
  logic            data_rd;
  logic            want;
  logic            ack_ok;
  logic            mem_dir;

  function automatic logic [15:0] bump(input logic [15:0] v);
    bump = v + 16'h0001;
  endfunction

  function automatic logic is_fdc(input logic [7:0] idx);
    is_fdc = (idx >= fdg_pkg::IDX_FDC_BASE) && (idx <= fdg_pkg::IDX_FDC_LAST);
  endfunction

  // Synchronised inputs: 4 drq, 3 intrq, 2 ready, 1 two-sided, 0 change
  assign expired = (q_r.cnt == fdg_pkg::COUNT_DONE);  // [R12]
  assign data_wr = bus.wr && (bus.addr == fdg_pkg::LOC_DATA);  // [R01]
  assign data_rd = bus.rd && (bus.addr == fdg_pkg::LOC_DATA);
  assign want    = q_r.loading ? !expired : q_r.s2[4];  // [R23]
  assign ack_ok  = bus.dma_ack && (q_r.st == fdg_pkg::FDG_REQ);  // [R15]
  assign mem_dir = q_r.loading || !q_r.ctrl[fdg_pkg::CTRL_TO_DISK];

  always_comb begin
    q_nxt        = q_r;
    q_nxt.s1     = {fdc_drq_i, fdc_intrq_i, drive_ready_i, two_sided_i, disk_change_i};
    q_nxt.s2     = q_r.s1;
    q_nxt.fdc_we = 1'b0;
    q_nxt.retrig = 1'b0;
    q_nxt.addr_low_preset_strobe   = 1'b0;
    q_nxt.addr_high_preset_strobe   = 1'b0;
    q_nxt.div    = (q_r.div == 7'(fdg_pkg::FDC_DIV - 1)) ? 7'h00 : q_r.div + 7'h01;  // [R22]

    // DMA cycle sequencing
    unique case (q_r.st)
      fdg_pkg::FDG_IDLE: begin
        if (bus.phi2_en && want) begin  // [R14]
          q_nxt.st = mem_dir ? fdg_pkg::FDG_FETCH : fdg_pkg::FDG_REQ;
        end
      end
      fdg_pkg::FDG_FETCH: begin
        q_nxt.dma_data = q_r.loading ? rom_data_i : fdc_rdata_i;
        q_nxt.st       = fdg_pkg::FDG_REQ;
      end
      fdg_pkg::FDG_REQ: begin
        if (ack_ok) begin
          if (!q_r.ctrl[fdg_pkg::CTRL_INC_N]) begin
            q_nxt.addr = bump(q_r.addr);  // [R10] [R24]
          end
          if (!expired) begin
            q_nxt.cnt = bump(q_r.cnt);  // [R11] [R24]
          end
          if (!mem_dir) begin
            q_nxt.fdc_wdata = bus.host_data;
            q_nxt.fdc_a     = fdg_pkg::FDC_REG_DATA;
            q_nxt.fdc_we    = 1'b1;
          end
          q_nxt.st = fdg_pkg::FDG_GAP;
        end
      end
      fdg_pkg::FDG_GAP: begin
        if (bus.phi2_en) begin
          q_nxt.st = fdg_pkg::FDG_IDLE;  // [R16]
        end
      end
    endcase

    if (q_r.loading && expired && q_r.st == fdg_pkg::FDG_IDLE) begin
      q_nxt.loading = 1'b0;  // [R23]
    end

    // Register port
    if (bus.wr && bus.addr == fdg_pkg::LOC_STATUS) begin
      q_nxt.idx = bus.wdata;  // [R02]
    end
    if (data_wr) begin
      if (is_fdc(q_r.idx)) begin
        q_nxt.fdc_wdata = bus.wdata;  // [R20]
        q_nxt.fdc_a     = q_r.idx[1:0];  // [R05]
        q_nxt.fdc_we    = 1'b1;
      end else begin
        unique case (q_r.idx)
          fdg_pkg::IDX_CTRL: begin
            q_nxt.ctrl   = bus.wdata;  // [R03] [R06] [R07]
            q_nxt.retrig = bus.wdata[fdg_pkg::CTRL_RETRIG];  // [R21]
          end
          fdg_pkg::IDX_ADDR_LO: begin
            q_nxt.addr[7:0] = bus.wdata;  // [R09]
            q_nxt.addr_low_preset_strobe      = 1'b1;
          end
          fdg_pkg::IDX_ADDR_HI: begin
            q_nxt.addr[15:8] = bus.wdata;  // [R09]
            q_nxt.addr_high_preset_strobe       = 1'b1;
          end
          fdg_pkg::IDX_CNT_LO: q_nxt.cnt[7:0]  = bus.wdata;  // [R11]
          fdg_pkg::IDX_CNT_HI: q_nxt.cnt[15:8] = bus.wdata;  // [R11]
          fdg_pkg::IDX_ROM_LOAD: q_nxt.loading = 1'b1;  // [R04]
          default: ;
        endcase
      end
    end

    if (bus.rd) begin
      q_nxt.rdata = 8'h00;
      if (bus.addr == fdg_pkg::LOC_STATUS) begin
        q_nxt.rdata[fdg_pkg::ST_READY]    = q_r.s2[2];  // [R08]
        q_nxt.rdata[fdg_pkg::ST_TWO_SIDE] = q_r.s2[1];
        q_nxt.rdata[fdg_pkg::ST_CHANGE]   = q_r.s2[0];
        q_nxt.rdata[fdg_pkg::ST_IRQ]      = q_r.s2[3];
        q_nxt.rdata[fdg_pkg::ST_LOAD_N]   = !q_r.loading;
      end else if (data_rd && is_fdc(q_r.idx)) begin
        q_nxt.rdata = fdc_rdata_i;  // [R05]
      end else if (data_rd && q_r.idx == fdg_pkg::IDX_ROM_LOAD) begin
        q_nxt.loading = 1'b1;  // [R04]
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_r      <= '0;
      q_r.ctrl <= fdg_pkg::CTRL_RST;
      q_r.cnt  <= fdg_pkg::COUNT_DONE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Controller chip access
  always_comb begin
    if (q_r.fdc_we) begin
      fdc_addr_o = q_r.fdc_a;
    end else if (q_r.st == fdg_pkg::FDG_FETCH) begin
      fdc_addr_o = fdg_pkg::FDC_REG_DATA;
    end else begin
      fdc_addr_o = q_r.idx[1:0];
    end
  end

  assign fdc_re_o = (data_rd && is_fdc(q_r.idx))
                    || (q_r.st == fdg_pkg::FDG_FETCH && !q_r.loading);
  assign fdc_we_o     = q_r.fdc_we;
  assign fdc_wdata_o  = q_r.fdc_wdata;
  assign fdc_clk_en_o = (q_r.div == 7'(fdg_pkg::FDC_DIV - 1));  // [R22]

  // Drive control outputs
  assign drive_pick_bit_lo_o        = q_r.ctrl[fdg_pkg::CTRL_DS_LO];  // [R06]
  assign drive_pick_bit_hi_o        = q_r.ctrl[fdg_pkg::CTRL_DS_HI];
  assign side_select_o              = q_r.ctrl[fdg_pkg::CTRL_SIDE];  // [R07]
  assign recording_density_select_o = q_r.ctrl[fdg_pkg::CTRL_RECORDING_DENSITY_SELECT];
  assign to_disk_o                  = q_r.ctrl[fdg_pkg::CTRL_TO_DISK];
  assign head_retrigger_o           = q_r.retrig;  // [R21]
  assign addr_low_preset_strobe_o   = q_r.addr_low_preset_strobe;  // [R09]
  assign addr_high_preset_strobe_o  = q_r.addr_high_preset_strobe;
  assign count_expired_flag_o       = expired;
  assign rom_addr_o                 = q_r.addr[ROM_AW-1:0];  // [R23]

  // Processor bus side
  assign bus.rdata                 = q_r.rdata;
  assign bus.transfer_request_line = (q_r.st == fdg_pkg::FDG_REQ)
                                     && bus.chain_level_grant;  // [R17]
  assign bus.chain_pass_next       = bus.chain_level_grant
                                     && (q_r.st != fdg_pkg::FDG_REQ);  // [R17]
  assign bus.map_swap_claim        = ack_ok;  // [R13]
  assign bus.valid_memory_strobe   = ack_ok && !expired;  // [R12]
  assign bus.address_drive_enable  = ack_ok;  // [R18]
  assign bus.data_drive_enable     = ack_ok && mem_dir;  // [R18]
  assign bus.mem_write             = mem_dir;
  assign bus.dma_addr              = q_r.addr;
  assign bus.dev_data              = q_r.dma_data;
  assign bus.irq_out               = 1'b0;
  assign bus.irq_oe_n = !(q_r.s2[3] && q_r.ctrl[fdg_pkg::CTRL_IRQ_EN]);  // [R19]

endmodule // fdg_card

// >>> fdg_chk_sva.sv
`timescale 1ns/1ps
module fdg_chk_sva (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        phi2_en,
  input wire logic        transfer_request_line,
  input wire logic        dma_ack,
  input wire logic        chain_level_grant,
  input wire logic        chain_pass_next,
  input wire logic        map_swap_claim,
  input wire logic        valid_memory_strobe,
  input wire logic        address_drive_enable,
  input wire logic        data_drive_enable,
  input wire logic [15:0] dma_addr,
  input wire logic        irq_out
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_claim_grant: assert property (map_swap_claim |-> dma_ack && transfer_request_line)
    else $error("claim outside a granted cycle");
  a_grant_claim: assert property (dma_ack && transfer_request_line |->
    map_swap_claim && address_drive_enable) else $error("granted cycle without claim");
  a_enable_ack: assert property (valid_memory_strobe || data_drive_enable |-> dma_ack)
    else $error("strobe or enable without grant");
  a_req_level: assert property (transfer_request_line |-> chain_level_grant)
    else $error("request while level disabled");
  a_chain_pass: assert property (chain_pass_next == (chain_level_grant && !transfer_request_line))
    else $error("chain pass wrong");
  a_ack_gap: assert property (dma_ack && transfer_request_line |=>
    !transfer_request_line [*8]) else $error("request too soon after grant");
  a_req_sync: assert property ($rose(transfer_request_line) && $past(chain_level_grant) |->
    $past(phi2_en) || $past(phi2_en, 2)) else $error("request not aligned to phase");
  a_addr_step: assert property (dma_ack && transfer_request_line |=>
    dma_addr == $past(dma_addr) + 16'h0001 || dma_addr == $past(dma_addr))
    else $error("address step wrong");
  a_irq_oc: assert property (irq_out == 1'b0)
    else $error("irq line driven high");
endmodule // fdg_chk_sva

// >>> fdg_host.sv
`timescale 1ns/1ps
module fdg_host (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  fdg_if.host              bus,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_wdata_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  output logic      [7:0]  cpu_rdata_o,
  input  wire logic        chain_enable_i,
  output logic      [15:0] mem_addr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             mem_we_o,
  output logic             mem_re_o,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             irq_n_o
);

  typedef struct packed {
    logic [7:0] phi;
    logic       ack;
  } fdg_host_state_t;

  fdg_host_state_t q_r;
  fdg_host_state_t q_nxt;
  logic            phi_pulse;

  assign phi_pulse = (q_r.phi == 8'(fdg_pkg::PHI_DIV - 1));

  always_comb begin
    q_nxt     = q_r;
    q_nxt.phi = phi_pulse ? 8'h00 : q_r.phi + 8'h01;
    // One-cycle grant per processor cycle
    q_nxt.ack = phi_pulse && bus.transfer_request_line && !q_r.ack;  // [R15]
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign bus.addr              = cpu_addr_i;
  assign bus.wdata             = cpu_wdata_i;
  assign bus.wr                = cpu_wr_i;
  assign bus.rd                = cpu_rd_i;
  assign bus.phi2_en           = phi_pulse;
  assign bus.dma_ack           = q_r.ack;
  assign bus.chain_level_grant = chain_enable_i;  // [R17]
  assign bus.host_data         = mem_rdata_i;
  assign cpu_rdata_o           = bus.rdata;
  assign mem_addr_o            = bus.dma_addr;
  assign mem_wdata_o           = bus.dev_data;
  assign mem_we_o = q_r.ack && bus.valid_memory_strobe && bus.mem_write;
  assign mem_re_o = q_r.ack && bus.valid_memory_strobe && !bus.mem_write;
  // Open-collector line resolved as a wire
  assign irq_n_o  = bus.irq_oe_n ? 1'b1 : bus.irq_out;

endmodule // fdg_host

// >>> fdg_if.sv
`timescale 1ns/1ps
interface fdg_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        phi2_en;
  logic        transfer_request_line;
  logic        dma_ack;
  logic        chain_level_grant;
  logic        chain_pass_next;
  logic        map_swap_claim;
  logic        valid_memory_strobe;
  logic        address_drive_enable;
  logic        data_drive_enable;
  logic        mem_write;
  logic [15:0] dma_addr;
  logic [7:0]  dev_data;
  logic [7:0]  host_data;
  logic        irq_out;
  logic        irq_oe_n;

  modport card (
    input  addr, wdata, wr, rd, phi2_en, dma_ack, chain_level_grant, host_data,
    output rdata, transfer_request_line, chain_pass_next, map_swap_claim,
    output valid_memory_strobe, address_drive_enable, data_drive_enable,
    output mem_write, dma_addr, dev_data, irq_out, irq_oe_n
  );

  modport host (
    output addr, wdata, wr, rd, phi2_en, dma_ack, chain_level_grant, host_data,
    input  rdata, transfer_request_line, chain_pass_next, map_swap_claim,
    input  valid_memory_strobe, address_drive_enable, data_drive_enable,
    input  mem_write, dma_addr, dev_data, irq_out, irq_oe_n
  );
endinterface // fdg_if

// >>> fdg_pkg.sv
package fdg_pkg;

  // Bus locations of the card
  localparam logic [15:0] LOC_DATA     = 16'hFCE0;
  localparam logic [15:0] LOC_STATUS   = 16'hFCE1;

  // Internal register indices
  localparam logic [7:0]  IDX_CTRL     = 8'h00;
  localparam logic [7:0]  IDX_ADDR_LO  = 8'h02;
  localparam logic [7:0]  IDX_ADDR_HI  = 8'h04;
  localparam logic [7:0]  IDX_CNT_LO   = 8'h06;
  localparam logic [7:0]  IDX_CNT_HI   = 8'h08;
  localparam logic [7:0]  IDX_ROM_LOAD = 8'h0A;
  localparam logic [7:0]  IDX_FDC_BASE = 8'h0C;
  localparam logic [7:0]  IDX_FDC_LAST = 8'h0F;

  // Controller chip register numbers
  localparam logic [1:0]  FDC_REG_DATA = 2'h3;

  // Control latch bit positions
  localparam int          CTRL_DS_LO   = 0;
  localparam int          CTRL_DS_HI   = 1;
  localparam int          CTRL_IRQ_EN  = 2;
  localparam int          CTRL_INC_N   = 3;
  localparam int          CTRL_TO_DISK = 4;
  localparam int          CTRL_SIDE    = 5;
  localparam int          CTRL_RETRIG  = 6;
  localparam int          CTRL_RECORDING_DENSITY_SELECT    = 7;

  // Status port bit positions
  localparam int          ST_READY     = 3;
  localparam int          ST_TWO_SIDE  = 4;
  localparam int          ST_CHANGE    = 5;
  localparam int          ST_IRQ       = 6;
  localparam int          ST_LOAD_N    = 7;

  // Values after reset
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] COUNT_DONE   = 16'hFFFF;

  // Clock rates and divider counts
  localparam int          MCLK_HZ      = 200_000_000;
  localparam int          FDC_CLK_HZ   = 2_000_000;
  localparam int          PHI_HZ       = 1_000_000;
  localparam int          FDC_DIV      = MCLK_HZ / FDC_CLK_HZ;
  localparam int          PHI_DIV      = MCLK_HZ / PHI_HZ;

  typedef enum logic [1:0] {
    FDG_IDLE  = 2'h0,
    FDG_FETCH = 2'h1,
    FDG_REQ   = 2'h3,
    FDG_GAP   = 2'h2
  } fdg_dma_st_t;

endpackage

// >>> test_disk_dma_port_glue.sv
`timescale 1ns/1ps
module test_disk_dma_port_glue;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [7:0]  cpu_wdata_i = 8'h00;
  logic        cpu_wr_i = 1'b0;
  logic        cpu_rd_i = 1'b0;
  logic        chain_enable_i = 1'b0;
  logic        fdc_drq_i = 1'b0;
  logic        fdc_intrq_i = 1'b0;
  logic        two_sided_i = 1'b0;
  logic        drive_ready_i = 1'b1;
  logic        disk_change_i = 1'b1;
  logic [7:0]  mem_rdata_i = 8'hC3;
  logic [7:0]  fdc_rdata_i = 8'h3C;
  logic [7:0]  cpu_rdata_o, mem_wdata_o, fdc_wdata_o, rom_data_i, rd_v;
  logic [15:0] mem_addr_o;
  logic [11:0] rom_addr_o;
  logic [1:0]  fdc_addr_o;
  logic [9:0]  fdc_last = 10'h3FF;
  logic        mem_we_o, mem_re_o, irq_n_o, fdc_re_o, fdc_we_o, fdc_clk_en_o;
  logic        drive_pick_bit_lo_o, drive_pick_bit_hi_o, side_select_o, to_disk_o;
  logic        recording_density_select_o, head_retrigger_o, count_expired_flag_o;
  logic        addr_low_preset_strobe_o, addr_high_preset_strobe_o;
  logic [4:0]  pins;
  int          fail_count = 0;
  int          checks = 0;
  int          retrig_n = 0;
  int          preset_n = 0;
  int          clk_n = 0;
  int          fre_n = 0;
  int          rdm_n = 0;

  fdg_if   fdg_if_inst ();
  fdg_host fdg_host_inst (
    .mclk_i         (mclk_i),
    .nrst_i         (nrst_i),
    .bus            (fdg_if_inst),
    .cpu_addr_i     (cpu_addr_i),
    .cpu_wdata_i    (cpu_wdata_i),
    .cpu_wr_i       (cpu_wr_i),
    .cpu_rd_i       (cpu_rd_i),
    .cpu_rdata_o    (cpu_rdata_o),
    .chain_enable_i (chain_enable_i),
    .mem_addr_o     (mem_addr_o),
    .mem_wdata_o    (mem_wdata_o),
    .mem_we_o       (mem_we_o),
    .mem_re_o       (mem_re_o),
    .mem_rdata_i    (mem_rdata_i),
    .irq_n_o        (irq_n_o)
  );
  fdg_card fdg_card_inst (
    .mclk_i                     (mclk_i),
    .nrst_i                     (nrst_i),
    .bus                        (fdg_if_inst),
    .fdc_addr_o                 (fdc_addr_o),
    .fdc_re_o                   (fdc_re_o),
    .fdc_we_o                   (fdc_we_o),
    .fdc_wdata_o                (fdc_wdata_o),
    .fdc_rdata_i                (fdc_rdata_i),
    .fdc_drq_i                  (fdc_drq_i),
    .fdc_intrq_i                (fdc_intrq_i),
    .fdc_clk_en_o               (fdc_clk_en_o),
    .drive_pick_bit_lo_o        (drive_pick_bit_lo_o),
    .drive_pick_bit_hi_o        (drive_pick_bit_hi_o),
    .side_select_o              (side_select_o),
    .recording_density_select_o (recording_density_select_o),
    .to_disk_o                  (to_disk_o),
    .head_retrigger_o           (head_retrigger_o),
    .addr_low_preset_strobe_o   (addr_low_preset_strobe_o),
    .addr_high_preset_strobe_o  (addr_high_preset_strobe_o),
    .count_expired_flag_o       (count_expired_flag_o),
    .drive_ready_i              (drive_ready_i),
    .two_sided_i                (two_sided_i),
    .disk_change_i              (disk_change_i),
    .rom_addr_o                 (rom_addr_o),
    .rom_data_i                 (rom_data_i)
  );
  fdg_chk_sva fdg_chk_sva_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .phi2_en(fdg_if_inst.phi2_en),
    .transfer_request_line(fdg_if_inst.transfer_request_line), .dma_ack(fdg_if_inst.dma_ack),
    .chain_level_grant(fdg_if_inst.chain_level_grant),
    .chain_pass_next(fdg_if_inst.chain_pass_next), .map_swap_claim(fdg_if_inst.map_swap_claim),
    .valid_memory_strobe(fdg_if_inst.valid_memory_strobe),
    .address_drive_enable(fdg_if_inst.address_drive_enable),
    .data_drive_enable(fdg_if_inst.data_drive_enable), .dma_addr(fdg_if_inst.dma_addr),
    .irq_out(fdg_if_inst.irq_out));

  always #2.5 mclk_i = ~mclk_i;
  assign rom_data_i = rom_addr_o[7:0] ^ 8'h5A;
  assign pins = {recording_density_select_o, side_select_o, to_disk_o,
                 drive_pick_bit_hi_o, drive_pick_bit_lo_o};
  always @(posedge mclk_i) begin
    if (head_retrigger_o === 1'b1) retrig_n++;
    if ((addr_low_preset_strobe_o | addr_high_preset_strobe_o) === 1'b1) preset_n++;
    if (fdc_we_o === 1'b1) fdc_last <= {fdc_addr_o, fdc_wdata_o};
    if (fdc_clk_en_o === 1'b1) clk_n++;
    if (fdc_re_o === 1'b1) fre_n++;
    if (mem_re_o === 1'b1) rdm_n++;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cpu_addr_i  <= a;
    cpu_wdata_i <= d;
    cpu_wr_i    <= 1'b1;
    @(posedge mclk_i);
    cpu_wr_i    <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge mclk_i);
    cpu_addr_i <= a;
    cpu_rd_i   <= 1'b1;
    @(posedge mclk_i);
    cpu_rd_i   <= 1'b0;
    #1 rd_v = cpu_rdata_o;
  endtask
  task rg(input logic [7:0] i, input logic [7:0] d);
    wr(16'hFCE1, i);
    wr(16'hFCE0, d);
  endtask
  task setup(input logic [7:0] c, input logic [15:0] a, input logic [15:0] n);
    rg(8'h00, c);
    rg(8'h02, a[7:0]);
    rg(8'h04, a[15:8]);
    rg(8'h06, n[7:0]);
    rg(8'h08, n[15:8]);
  endtask
  task dma(input int cyc, input logic [15:0] a0, input logic inc, input logic rom,
           input logic drq, input int exp_n);
    int k;
    int n;
    n = 0;
    @(posedge mclk_i);
    fdc_drq_i <= drq;
    for (k = 0; k < cyc; k++) begin
      @(posedge mclk_i);
      #1;
      if (mem_we_o === 1'b1) begin
        chk(mem_addr_o, inc ? a0 + 16'(n) : a0);
        chk(16'(mem_wdata_o), rom ? 16'((a0[7:0] + 8'(n)) ^ 8'h5A) : 16'h003C);
        n++;
      end
    end
    chk(16'(n), 16'(exp_n));
    @(posedge mclk_i);
    fdc_drq_i <= 1'b0;
    repeat (600) @(posedge mclk_i);
  endtask

  task t_regs;
    rd(16'hFCE1);
    chk(16'(rd_v), 16'h00A8);
    rd(16'hFCE2);
    chk(16'(rd_v), 16'h0000);
    rg(8'h0C, 8'h5A);
    repeat (2) @(posedge mclk_i);
    chk(16'(fdc_last), 16'h005A);
    wr(16'hFCE1, 8'h0E);
    rd(16'hFCE0);
    chk(16'(rd_v), 16'h003C);
    chk(16'(fre_n), 16'h0001);
    $display("register test done");
  endtask
  task t_ctrl;
    int k0;
    rg(8'h00, 8'hB5);
    repeat (2) @(posedge mclk_i);
    fdc_intrq_i <= 1'b1;
    #1;
    chk(16'(pins), 16'h001D);
    chk(16'(retrig_n), 16'h0000);
    rg(8'h00, 8'h4E);
    repeat (5) @(posedge mclk_i);
    #1;
    chk(16'(pins), 16'h0002);
    chk(16'(retrig_n), 16'h0001);
    chk(16'(irq_n_o), 16'h0000);
    rd(16'hFCE1);
    chk(16'(rd_v), 16'h00E8);
    rg(8'h00, 8'h00);
    repeat (5) @(posedge mclk_i);
    fdc_intrq_i <= 1'b0;
    #1;
    chk(16'(irq_n_o), 16'h0001);
    @(posedge mclk_i);
    #1;
    k0 = clk_n;
    repeat (1000) @(posedge mclk_i);
    #1;
    chk(16'(clk_n - k0), 16'h000A);
    $display("control test done");
  endtask
  task t_dma;
    setup(8'h00, 16'h1234, 16'hFFFD);
    #1;
    chk(mem_addr_o, 16'h1234);
    dma(800, 16'h1234, 1'b1, 1'b0, 1'b1, 0);
    chain_enable_i <= 1'b1;
    chk(16'(preset_n), 16'h0002);
    dma(1600, 16'h1234, 1'b1, 1'b0, 1'b1, 2);
    chk(16'(count_expired_flag_o), 16'h0001);
    setup(8'h08, 16'h2000, 16'hFFFD);
    dma(1600, 16'h2000, 1'b0, 1'b0, 1'b1, 2);
    $display("disk read test done");
  endtask
  task t_write;
    setup(8'h10, 16'h3000, 16'hFFFE);
    dma(1200, 16'h3000, 1'b1, 1'b0, 1'b1, 0);
    chk(16'(fdc_last), 16'h03C3);
    chk(16'(rdm_n), 16'h0001);
    $display("disk write test done");
  endtask
  task t_rom;
    setup(8'h00, 16'h0800, 16'hFFFD);
    rg(8'h0A, 8'h00);
    rd(16'hFCE1);
    chk(16'(rd_v), 16'h0028);
    dma(1600, 16'h0800, 1'b1, 1'b1, 1'b0, 2);
    rd(16'hFCE1);
    chk(16'(rd_v), 16'h00A8);
    setup(8'h00, 16'h0810, 16'hFFFE);
    wr(16'hFCE1, 8'h0A);
    rd(16'hFCE0);
    rd(16'hFCE1);
    chk(16'(rd_v), 16'h0028);
    dma(1200, 16'h0810, 1'b1, 1'b1, 1'b0, 1);
    $display("rom load test done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_regs;
    t_ctrl;
    t_dma;
    t_write;
    t_rom;
    summarize;
  end
endmodule // test_disk_dma_port_glue
